// *** inc/sbpc_pkg.sv ***
// constants and types for the scsi bus pin control block
package sbpc_pkg;
    localparam int SBPC_DATA_W   = 8;
    localparam int SBPC_CTL_W    = 9;
    // control vector bit positions, active high internally
    localparam int SBPC_BIT_BSY  = 0;
    localparam int SBPC_BIT_SEL  = 1;
    localparam int SBPC_BIT_ATN  = 2;
    localparam int SBPC_BIT_ACK  = 3;
    localparam int SBPC_BIT_RST  = 4;
    localparam int SBPC_BIT_MSG  = 5;
    localparam int SBPC_BIT_CD   = 6;
    localparam int SBPC_BIT_REQ  = 7;
    localparam int SBPC_BIT_IO   = 8;
    localparam logic [SBPC_CTL_W-1:0] SBPC_CTL_IDLE = 9'h000;
    localparam logic [SBPC_DATA_W-1:0] SBPC_DATA_IDLE = 8'h00;

    typedef enum logic [4:0] {
        SBPC_IDLE      = 5'h01,
        SBPC_ARBITRATE = 5'h02,
        SBPC_SELECT    = 5'h04,
        SBPC_INITIATOR = 5'h08,
        SBPC_TARGET    = 5'h10
    } sbpc_state_t;

    // odd parity bit over a data byte
    function automatic logic sbpc_odd_parity(input logic [SBPC_DATA_W-1:0] d);
        sbpc_odd_parity = ~(^d);
    endfunction
endpackage

// *** rtl/sbpc_sync.sv ***
// two-flop synchroniser for the incoming scsi control lines
module sbpc_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sbpc_sync_t;
    sbpc_sync_t r;
    sbpc_sync_t next_r;
    always_comb begin
        next_r = r;
        if (ce_in) begin
            next_r.first  = async_in;
            next_r.second = r.first;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign sync_out = r.second;
endmodule

// *** rtl/sbpc_parity.sv ***
// registered odd parity generator and checker for the data bus
module sbpc_parity #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] data_in,
    input  wire logic             parity_in,
    input  wire logic             check_in,
    output logic                  parity_out,
    output logic                  error_out
);
    import sbpc_pkg::*;
    typedef struct packed {
        logic par;
        logic err;
    } sbpc_par_t;
    sbpc_par_t r;
    sbpc_par_t next_r;
    always_comb begin
        next_r = r;
        if (ce_in) begin
            next_r.par = sbpc_odd_parity(data_in);
            next_r.err = check_in && (parity_in != sbpc_odd_parity(data_in));
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign parity_out = r.par;
    assign error_out  = r.err;
endmodule

// *** rtl/sbpc_top.sv ***
// scsi bus pin control: pin drivers, role flags and external driver enables
module sbpc_top (
    input  wire logic                            clk_in,
    input  wire logic                            rst_in,
    input  wire logic                            ce_in,
    // user side requests
    input  wire logic                            arb_req_in,
    input  wire logic                            won_in,
    input  wire logic                            as_target_in,
    input  wire logic                            release_in,
    input  wire logic                            drive_data_in,
    input  wire logic [sbpc_pkg::SBPC_DATA_W-1:0] tx_data_in,
    input  wire logic                            tx_cd_in,
    input  wire logic                            tx_io_in,
    input  wire logic                            tx_msg_in,
    input  wire logic                            tx_atn_in,
    input  wire logic                            tx_req_in,
    input  wire logic                            tx_ack_in,
    // scsi bus pins, active low on the wire
    input  wire logic [sbpc_pkg::SBPC_DATA_W-1:0] db_n_in,
    input  wire logic                            bus_parity_line_n_in,
    input  wire logic [sbpc_pkg::SBPC_CTL_W-1:0]  ctl_n_in,
    output logic      [sbpc_pkg::SBPC_DATA_W-1:0] db_n_out,
    output logic      [sbpc_pkg::SBPC_DATA_W-1:0] db_oe_out,
    output logic                                 bus_parity_line_n_out,
    output logic                                 bus_parity_line_oe_out,
    output logic      [sbpc_pkg::SBPC_CTL_W-1:0]  ctl_n_out,
    output logic      [sbpc_pkg::SBPC_CTL_W-1:0]  ctl_oe_out,
    // external driver control
    output logic                                 data_driver_enable_out,
    output logic                                 originator_role_flag_out,
    output logic                                 responder_role_flag_out,
    output logic                                 contention_phase_flag_out,
    output logic                                 busy_driver_enable_out,
    output logic                                 select_driver_enable_out,
    // received and status
    output logic      [sbpc_pkg::SBPC_DATA_W-1:0] rx_data_out,
    output logic      [sbpc_pkg::SBPC_CTL_W-1:0]  rx_ctl_out,
    output logic                                 bus_busy_out,
    output logic                                 bus_reset_out,
    output logic                                 parity_error_out
);
    import sbpc_pkg::*;

    typedef struct packed {
        sbpc_state_t                state;
        logic [SBPC_DATA_W-1:0]     db_n;
        logic [SBPC_DATA_W-1:0]     db_oe;
        logic                       par_oe;
        logic [SBPC_CTL_W-1:0]      ctl_n;
        logic [SBPC_CTL_W-1:0]      ctl_oe;
        logic                       dde;
        logic                       init;
        logic                       targ;
        logic                       arb;
        logic                       bde;
        logic                       sde;
        logic [SBPC_DATA_W-1:0]     rx_data;
        logic [SBPC_CTL_W-1:0]      rx_ctl;
        logic                       busy;
        logic                       brst;
    } sbpc_reg_t;

    sbpc_reg_t r;
    sbpc_reg_t next_r;
    logic [SBPC_CTL_W-1:0] ctl_sync;
    logic                  par_err;
    logic                  checking;
    logic [SBPC_CTL_W-1:0] drv;
    logic                  drv_data;

    sbpc_sync #(
        .WIDTH (SBPC_CTL_W)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .async_in (~ctl_n_in),
        .sync_out (ctl_sync)
    );

    // check incoming parity only while listening to the data bus
    assign checking = ~drv_data;

    sbpc_parity #(
        .WIDTH (SBPC_DATA_W)
    ) u_par (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .data_in    (drv_data ? tx_data_in : ~db_n_in),
        .parity_in  (~bus_parity_line_n_in),
        .check_in   (checking),
        .parity_out (),
        .error_out  (par_err)
    );

    always_comb begin
        next_r   = r;
        drv      = SBPC_CTL_IDLE;
        drv_data = 1'b0;
        case (r.state)
            SBPC_IDLE: begin
                if (arb_req_in && !ctl_sync[SBPC_BIT_BSY] && !ctl_sync[SBPC_BIT_SEL]) begin
                    next_r.state = SBPC_ARBITRATE;
                end
            end
            SBPC_ARBITRATE: begin
                drv[SBPC_BIT_BSY] = 1'b1;
                drv_data          = 1'b1;
                if (won_in) begin
                    next_r.state = SBPC_SELECT;
                end else if (release_in) begin
                    next_r.state = SBPC_IDLE;
                end
            end
            SBPC_SELECT: begin
                // busy released here; the peer's busy is only trusted once select is seen
                drv[SBPC_BIT_SEL] = 1'b1;
                drv[SBPC_BIT_IO]  = as_target_in;
                drv_data          = 1'b1;
                if (release_in) begin
                    next_r.state = SBPC_IDLE;
                end else if (ctl_sync[SBPC_BIT_BSY] && ctl_sync[SBPC_BIT_SEL]
                             && !drive_data_in) begin
                    next_r.state = as_target_in ? SBPC_TARGET : SBPC_INITIATOR;
                end
            end
            SBPC_INITIATOR: begin
                drv[SBPC_BIT_ATN] = tx_atn_in;
                drv[SBPC_BIT_ACK] = tx_ack_in;
                drv_data = drive_data_in && !ctl_sync[SBPC_BIT_IO];
                if (release_in || !ctl_sync[SBPC_BIT_BSY]) begin
                    next_r.state = SBPC_IDLE;
                end
            end
            SBPC_TARGET: begin
                drv[SBPC_BIT_BSY] = 1'b1;
                drv[SBPC_BIT_CD]  = tx_cd_in;
                drv[SBPC_BIT_IO]  = tx_io_in;
                drv[SBPC_BIT_MSG] = tx_msg_in;
                drv[SBPC_BIT_REQ] = tx_req_in;
                drv_data          = drive_data_in && tx_io_in;
                if (release_in) begin
                    next_r.state = SBPC_IDLE;
                end
            end
            default: begin
                next_r.state = SBPC_IDLE;
            end
        endcase
        if (ctl_sync[SBPC_BIT_RST]) begin
            next_r.state = SBPC_IDLE;
            drv          = SBPC_CTL_IDLE;
            drv_data     = 1'b0;
        end
        // open drain: drive low where asserted, float otherwise
        next_r.ctl_oe  = drv;
        next_r.ctl_n   = SBPC_CTL_IDLE;
        next_r.db_n    = ~tx_data_in;
        next_r.db_oe   = drv_data ? tx_data_in : SBPC_DATA_IDLE;
        next_r.par_oe  = drv_data && sbpc_odd_parity(tx_data_in);
        next_r.dde     = drv_data;
        next_r.bde     = drv[SBPC_BIT_BSY];
        next_r.sde     = drv[SBPC_BIT_SEL];
        // flags follow the state that drives the lines, so they align with the enables
        next_r.init    = (r.state == SBPC_INITIATOR) && !ctl_sync[SBPC_BIT_RST];
        next_r.targ    = (r.state == SBPC_TARGET) && !ctl_sync[SBPC_BIT_RST];
        next_r.arb     = (r.state == SBPC_ARBITRATE) && !ctl_sync[SBPC_BIT_RST];
        next_r.rx_data = ~db_n_in;
        next_r.rx_ctl  = ctl_sync;
        next_r.busy    = ctl_sync[SBPC_BIT_BSY];
        next_r.brst    = ctl_sync[SBPC_BIT_RST];
        if (!ce_in) begin
            next_r = r;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r       <= '0;
            r.state <= SBPC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign db_n_out                  = r.db_n;
    assign db_oe_out                 = r.db_oe;
    assign bus_parity_line_n_out     = 1'b0;
    assign bus_parity_line_oe_out    = r.par_oe;
    assign ctl_n_out                 = r.ctl_n;
    assign ctl_oe_out                = r.ctl_oe;
    assign data_driver_enable_out    = r.dde;
    assign originator_role_flag_out  = r.init;
    assign responder_role_flag_out   = r.targ;
    assign contention_phase_flag_out = r.arb;
    assign busy_driver_enable_out    = r.bde;
    assign select_driver_enable_out  = r.sde;
    assign rx_data_out               = r.rx_data;
    assign rx_ctl_out                = r.rx_ctl;
    assign bus_busy_out              = r.busy;
    assign bus_reset_out             = r.brst;
    assign parity_error_out          = par_err;
endmodule

// *** test/sbpc_monitor.sv ***
// checker for the scsi bus pin control outputs
module sbpc_monitor (
    input wire logic                            clk_in,
    input wire logic                            rst_in,
    input wire logic                            arb_req_in,
    input wire logic [sbpc_pkg::SBPC_CTL_W-1:0]  ctl_n_in,
    input wire logic [sbpc_pkg::SBPC_DATA_W-1:0] db_oe_out,
    input wire logic                            bus_parity_line_oe_out,
    input wire logic [sbpc_pkg::SBPC_CTL_W-1:0]  ctl_oe_out,
    input wire logic                            data_driver_enable_out,
    input wire logic                            originator_role_flag_out,
    input wire logic                            responder_role_flag_out,
    input wire logic                            contention_phase_flag_out,
    input wire logic                            busy_driver_enable_out,
    input wire logic                            select_driver_enable_out,
    input wire logic                            bus_busy_out,
    input wire logic                            bus_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbpc_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_den; (db_oe_out != 8'h00) |-> data_driver_enable_out; endproperty
    a_den: assert property (p_den) else $error("data pulled without enable");
    property p_par; data_driver_enable_out |-> bus_parity_line_oe_out == ~^db_oe_out; endproperty
    a_par: assert property (p_par) else $error("driven parity not odd");
    property p_drv; {select_driver_enable_out, busy_driver_enable_out} == ctl_oe_out[1:0]; endproperty
    a_drv: assert property (p_drv) else $error("driver enable mismatch");
    property p_arb; contention_phase_flag_out |-> busy_driver_enable_out && !originator_role_flag_out && !responder_role_flag_out; endproperty
    a_arb: assert property (p_arb) else $error("arbitration flags wrong");
    property p_start; $rose(contention_phase_flag_out) |-> $past(arb_req_in); endproperty
    a_start: assert property (p_start) else $error("arbitration without request");
    property p_rel; $fell(rst_in) |-> ctl_oe_out == 9'h000 && db_oe_out == 8'h00; endproperty
    a_rel: assert property (p_rel) else $error("lines driven at reset release");
    property p_busy; (!ctl_n_in[SBPC_BIT_BSY]) [*4] |-> bus_busy_out; endproperty
    a_busy: assert property (p_busy) else $error("busy line not reported");
    property p_brst; (!ctl_n_in[SBPC_BIT_RST]) [*4] |-> bus_reset_out && ctl_oe_out[1:0] == 2'h0; endproperty
    a_brst: assert property (p_brst) else $error("bus reset not obeyed");
endmodule
bind sbpc_top sbpc_monitor i_mon (.*);

// *** test/sbpc_peer.sv ***
// partner model: scsi peer answering selection and driving data
module sbpc_peer (
    input  wire logic       clk_in,
    input  wire logic [8:0] ctl_n_in,
    input  wire logic       answer_in,
    input  wire logic       hold_bsy_in,
    input  wire logic       send_in,
    input  wire logic       bad_par_in,
    input  wire logic [7:0] data_in,
    input  wire logic [3:0] lat_in,
    output logic      [8:0] ctl_oe_out,
    output logic      [7:0] db_oe_out,
    output logic            par_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic       on  = 1'b0;
    always @(posedge clk_in) begin
        cnt <= (answer_in && !ctl_n_in[1]) ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
        on <= answer_in && (on || cnt > lat_in);
    end
    assign ctl_oe_out = {8'h00, hold_bsy_in | on};
    assign db_oe_out = send_in ? data_in : 8'h00;
    assign par_oe_out = send_in & (~^data_in ^ bad_par_in);
endmodule

// *** test/tb.sv ***
// testbench for the scsi bus pin control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sbpc_pkg::*;
    logic       clk_in = 0, rst_in = 1, ce_in = 1, ans = 0, hold = 0, send = 0, bad = 0;
    logic       arb_req_in = 0, won_in = 0, as_target_in = 0, release_in = 0, brst = 0;
    logic       drive_data_in = 0, tx_cd_in = 0, tx_io_in = 0, tx_msg_in = 0, p_par;
    logic       tx_atn_in = 0, tx_req_in = 0, tx_ack_in = 0, bus_parity_line_n_out;
    logic       bus_parity_line_oe_out, data_driver_enable_out, originator_role_flag_out;
    logic       responder_role_flag_out, contention_phase_flag_out, busy_driver_enable_out;
    logic       select_driver_enable_out, bus_busy_out, bus_reset_out, parity_error_out;
    logic [3:0] lat = 0;
    logic [7:0] tx_data_in = 0, pdata = 0, db_oe_out, db_n_out, rx_data_out, p_db;
    logic [8:0] ctl_oe_out, ctl_n_out, rx_ctl_out, p_ctl;
    logic [8:0] rows [5] = '{9'h100, 9'h001, 9'h1FF, 9'h1A5, 9'h007};
    int         n_errors = 0, total_checks = 0, cycles = 0, i, k;
    wire logic [7:0] db_n_in = ~(db_oe_out | p_db);
    wire logic       bus_parity_line_n_in = ~(bus_parity_line_oe_out | p_par);
    wire logic [8:0] ctl_n_in = ~(ctl_oe_out | p_ctl | {4'h0, brst, 4'h0});
    sbpc_top i_dut (.*);
    sbpc_peer i_peer (.clk_in(clk_in), .ctl_n_in(ctl_n_in), .answer_in(ans), .hold_bsy_in(hold),
        .send_in(send), .bad_par_in(bad), .data_in(pdata), .lat_in(lat),
        .ctl_oe_out(p_ctl), .db_oe_out(p_db), .par_oe_out(p_par));
    initial forever #20 clk_in = ~clk_in;
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 2000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic idle;
        {arb_req_in, won_in, as_target_in, ans, drive_data_in} = 5'h00;
        release_in = 1;
        cyc(1);
        release_in = 0;
        cyc(4);
    endtask
    task automatic poll_role;
        for (k = 0; k < 20 && !(originator_role_flag_out | responder_role_flag_out); k++) cyc(1);
    endtask
    initial begin
        cyc(8);
        chk(ctl_oe_out, 9'h000);
        chk({busy_driver_enable_out, data_driver_enable_out, db_oe_out}, 9'h000);
        rst_in = 0;
        cyc(2);
        for (i = 0; i < 5; i++) begin
            tx_data_in = rows[i][7:0];
            arb_req_in = 1;
            cyc(2);
            chk(contention_phase_flag_out, 9'h001);
            chk(busy_driver_enable_out, 9'h001);
            chk(data_driver_enable_out, 9'h001);
            chk(db_oe_out, rows[i][7:0]);
            chk(bus_parity_line_oe_out, rows[i][8]);
            idle();
            chk(data_driver_enable_out, 9'h000);
        end
        // selection with a slow target
        lat = 4'h3;
        ans = 1;
        arb_req_in = 1;
        cyc(1);
        won_in = 1;
        cyc(2);
        chk(select_driver_enable_out, 9'h001);
        chk(busy_driver_enable_out, 9'h000);
        chk(contention_phase_flag_out, 9'h000);
        poll_role();
        chk({originator_role_flag_out, responder_role_flag_out}, 9'h002);
        idle();
        chk(originator_role_flag_out, 9'h000);
        // reselection as target
        {tx_io_in, tx_cd_in, tx_msg_in, as_target_in, ans, arb_req_in} = 6'h3F;
        lat = 4'h0;
        cyc(1);
        won_in = 1;
        poll_role();
        chk({originator_role_flag_out, responder_role_flag_out}, 9'h001);
        drive_data_in = 1;
        cyc(2);
        chk(data_driver_enable_out, 9'h001);
        chk(ctl_oe_out[8:5], 9'h00B);
        idle();
        {tx_io_in, tx_cd_in, tx_msg_in} = 3'h0;
        // busy bus refuses arbitration
        hold = 1;
        cyc(4);
        chk(bus_busy_out, 9'h001);
        arb_req_in = 1;
        cyc(2);
        chk(contention_phase_flag_out, 9'h000);
        {arb_req_in, hold} = 2'h0;
        cyc(4);
        // received byte and parity
        pdata = 8'h3C;
        send = 1;
        cyc(4);
        chk(rx_data_out, 9'h03C);
        chk(parity_error_out, 9'h000);
        bad = 1;
        cyc(2);
        chk(parity_error_out, 9'h001);
        {send, bad} = 2'h0;
        // bus reset line during arbitration
        arb_req_in = 1;
        cyc(1);
        brst = 1;
        cyc(5);
        chk(bus_reset_out, 9'h001);
        chk({busy_driver_enable_out, contention_phase_flag_out}, 9'h000);
        {brst, arb_req_in} = 2'h0;
        cyc(4);
        // component reset in mid-run
        arb_req_in = 1;
        cyc(1);
        rst_in = 1;
        cyc(1);
        chk(ctl_oe_out, 9'h000);
        chk(data_driver_enable_out, 9'h000);
        {rst_in, arb_req_in} = 2'h0;
        cyc(2);
        test_done();
    end
endmodule
